/* verilog/tmr_regs.svh */
// Register offsets, field positions, codes and reset values of the 8-bit timer
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// Register byte addresses
`define TMR_CTRL_ADDR 12'h000
`define TMR_MATCH_ADDR 12'h004
`define TMR_STAT_ADDR 12'h008
`define TMR_MASK_ADDR 12'h00c

// Control register fields
`define TMR_CS_LSB 0
`define TMR_CS_MSB 2
`define TMR_EDGE_BIT 3
`define TMR_RUN_BIT 4
`define TMR_MODE_LSB 5
`define TMR_MODE_MSB 6
`define TMR_FF_LSB 7
`define TMR_FF_MSB 8
`define TMR_CTRL_W 9
`define TMR_CTRL_RST 9'h180

// Mode field codes
`define TMR_MODE_TIMER 2'h0
`define TMR_MODE_EVENT 2'h1
`define TMR_MODE_DIV 2'h2
`define TMR_MODE_PWM 2'h3

// Flip-flop control field codes
`define TMR_FF_CLEAR 2'h0
`define TMR_FF_SET 2'h1
`define TMR_FF_KEEP 2'h3

// Status and mask layout
`define TMR_STAT_MATCH 0
`define TMR_STAT_FF 1
`define TMR_STAT_CNT_LSB 8
`define TMR_STAT_CNT_MSB 15

// Source clock codes and prescaler exponents (pclk taken as fc)
`define TMR_CS_SLOW 3'h0
`define TMR_CS_FAST_MIN 3'h5
`define TMR_EXP_0 4'hb
`define TMR_EXP_1 4'h7
`define TMR_EXP_2 4'h3
`define TMR_EXP_4 4'h5
`define TMR_EXP_5 4'h2
`define TMR_EXP_6 4'h1
`define TMR_EXP_7 4'h0
`define TMR_PRESC_W 11

// Counter limits
`define TMR_CNT_ZERO 8'h00
`define TMR_CNT_MAX 8'hff

`endif

/* verilog/tmr_pkg.sv */
// Types shared by the 8-bit timer files
package tmr_pkg;
	typedef enum logic [1:0] {tmr_timer, tmr_event, tmr_divider, tmr_pwm} tmr_mode_t;
endpackage

/* verilog/tmr_clk_sel.sv */
// Prescaler and source clock selection producing a one-cycle count tick
`timescale 1ns/10ps
`default_nettype none
`include "tmr_regs.svh"

module tmr_clk_sel (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Control
	input wire logic run,
	input wire logic [2:0] sel,
	input wire logic pwm_mode,
	input wire logic low_freq,
	// Tick out
	output logic tick
);
	logic [`TMR_PRESC_W-1:0] presc;
	logic [`TMR_PRESC_W-1:0] next_presc;
	logic [`TMR_PRESC_W-1:0] mask;
	logic [3:0] expo;
	logic valid;
	logic allowed;

	// Exponent per source code; code 011 has no source
	always_comb begin
		valid = 1'b1;
		case (sel)
			3'h0: expo = `TMR_EXP_0;
			3'h1: expo = `TMR_EXP_1;
			3'h2: expo = `TMR_EXP_2;
			3'h4: expo = `TMR_EXP_4;
			3'h5: expo = `TMR_EXP_5;
			3'h6: expo = `TMR_EXP_6;
			3'h7: expo = `TMR_EXP_7;
			default: begin
				expo = `TMR_EXP_7;
				valid = 1'b0;
			end
		endcase
	end

	// Fast codes only feed PWM; slow operation only offers code 000
	assign allowed = valid && (sel < `TMR_CS_FAST_MIN || pwm_mode) && (!low_freq || sel == `TMR_CS_SLOW);
	assign mask = ~({`TMR_PRESC_W{1'b1}} << expo);
	assign tick = run && allowed && ((presc & mask) == mask);

	// Prescaler restarts from zero on every start, so the first period is whole
	always_comb begin
		next_presc = presc;
		if (!run)
			next_presc = '0;
		else
			next_presc = presc + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			presc <= '0;
		else if (ce)
			presc <= next_presc;
	end
endmodule
`default_nettype wire

/* verilog/tmr_event_sync.sv */
// Event pin synchroniser with selectable edge detection
`timescale 1ns/10ps
`default_nettype none

module tmr_event_sync (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Pin and edge choice
	input wire logic event_input_pin,
	input wire logic edge_select,
	// Detected edge
	output logic event_pulse
);
	logic sync1;
	logic sync2;
	logic prev;

	// Two stages before use; the pin is asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev <= 1'b0;
		end else if (ce) begin
			sync1 <= event_input_pin;
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	// Pulses shorter than one clock may be missed
	assign event_pulse = ce && (edge_select ? (prev && !sync2) : (!prev && sync2));
endmodule
`default_nettype wire

/* verilog/tmr_timer8.sv */
// 8-bit timer/counter with divider and PWM output, APB register slave
//
// What this block does
// - Control and match registers are write-only and read as zero.
// - Reset leaves the match value untouched; only writes change it.
// - Timer mode counts internal ticks, on match interrupts, clears, continues.
// - Timer codes 000, 001, 010, 100; slow operation allows only 000.
// - Event mode counts pin edges, on match interrupts, clears, continues.
// - Divider mode toggles flip-flop on match, clears, interrupts each toggle.
// - Flip-flop resets to 0 and software may preset it.
// - PWM toggles on match, toggles again at overflow, clears and interrupts.
// - Inverted flip-flop drives the shared pin in divider and PWM modes.
// - PWM match value is double-buffered, taken at the end of each period.
// - Setting the run bit copies the first PWM value to the compare stage.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_regs.svh"

module tmr_timer8 (
	// Clock, enable and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic event_input_pin,
	input wire logic low_freq_mode,
	output logic shared_port_pin,
	// Interrupt
	output logic match_interrupt
);
	// Register state
	logic [`TMR_CTRL_W-1:0] pwm_timer_control;
	logic [`TMR_CTRL_W-1:0] next_pwm_timer_control;
	logic [7:0] match_value_register;
	logic [7:0] next_match_value_register;
	logic [1:0] status;
	logic [1:0] next_status;
	logic [1:0] mask;
	logic [1:0] next_mask;
	logic [31:0] next_prdata;

	// Core state
	logic [7:0] count;
	logic [7:0] next_count;
	logic [7:0] active_match;
	logic [7:0] next_active_match;
	logic output_flipflop;
	logic next_output_flipflop;
	logic run_prev;
	logic next_run_prev;

	// Synchroniser for the slow operation pin
	logic slow_s1;
	logic slow_s2;

	// Decoded control and bus strobes
	logic run_bit;
	logic edge_select;
	logic [2:0] clock_select_field;
	logic [1:0] flipflop_ctrl_field;
	tmr_pkg::tmr_mode_t mode;
	logic wr_en;
	logic rd_setup;
	logic ctrl_wr;
	logic match_wr;
	logic stat_wr;
	logic mask_wr;
	logic addr_ok;
	logic clk_tick;
	logic ev_pulse;
	logic step;
	logic match_evt;
	logic [7:0] count_inc;

	// Control field decode
	assign run_bit = pwm_timer_control[`TMR_RUN_BIT];
	assign edge_select = pwm_timer_control[`TMR_EDGE_BIT];
	assign clock_select_field = pwm_timer_control[`TMR_CS_MSB:`TMR_CS_LSB];
	assign flipflop_ctrl_field = pwm_timer_control[`TMR_FF_MSB:`TMR_FF_LSB];

	// Mode field to operating mode
	always_comb begin
		case (pwm_timer_control[`TMR_MODE_MSB:`TMR_MODE_LSB])
			`TMR_MODE_TIMER: mode = tmr_pkg::tmr_timer;
			`TMR_MODE_EVENT: mode = tmr_pkg::tmr_event;
			`TMR_MODE_DIV: mode = tmr_pkg::tmr_divider;
			`TMR_MODE_PWM: mode = tmr_pkg::tmr_pwm;
			default: mode = tmr_pkg::tmr_timer;
		endcase
	end

	// Slow operation level crosses in through two flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_s1 <= 1'b0;
			slow_s2 <= 1'b0;
		end else if (ce) begin
			slow_s1 <= low_freq_mode;
			slow_s2 <= slow_s1;
		end
	end

	// Internal source clock
	tmr_clk_sel u_clk_sel (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.run(run_bit),
		.sel(clock_select_field),
		.pwm_mode(mode == tmr_pkg::tmr_pwm),
		.low_freq(slow_s2),
		.tick(clk_tick)
	);

	// External event edges
	tmr_event_sync u_event (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.event_input_pin(event_input_pin),
		.edge_select(edge_select),
		.event_pulse(ev_pulse)
	);

	// APB decode; registers answer without wait states while enabled
	assign pready = ce;
	assign wr_en = psel && penable && pwrite && ce;
	assign rd_setup = psel && !penable && !pwrite && ce;
	assign addr_ok = (paddr == `TMR_CTRL_ADDR) || (paddr == `TMR_MATCH_ADDR) ||
		(paddr == `TMR_STAT_ADDR) || (paddr == `TMR_MASK_ADDR);
	assign pslverr = psel && penable && !addr_ok;
	assign ctrl_wr = wr_en && (paddr == `TMR_CTRL_ADDR);
	assign match_wr = wr_en && (paddr == `TMR_MATCH_ADDR);
	assign stat_wr = wr_en && (paddr == `TMR_STAT_ADDR);
	assign mask_wr = wr_en && (paddr == `TMR_MASK_ADDR);

	// Count step comes from the pin in event mode, else from the prescaler
	assign step = run_bit && ((mode == tmr_pkg::tmr_event) ? ev_pulse : clk_tick);
	assign count_inc = count + 1'b1;

	// Counter, compare stage and output flip-flop
	always_comb begin
		next_count = count;
		next_active_match = active_match;
		next_output_flipflop = output_flipflop;
		next_run_prev = run_bit;
		match_evt = 1'b0;
		if (!run_bit) begin
			next_count = `TMR_CNT_ZERO;
		end else if (!run_prev) begin
			// First start takes the written value straight into the compare stage
			next_active_match = match_value_register;
			next_count = `TMR_CNT_ZERO;
		end else if (step) begin
			case (mode)
				tmr_pkg::tmr_timer, tmr_pkg::tmr_event: begin
					if (count_inc == match_value_register) begin
						next_count = `TMR_CNT_ZERO;
						match_evt = 1'b1;
					end else begin
						next_count = count_inc;
					end
				end
				tmr_pkg::tmr_divider: begin
					if (count_inc == match_value_register) begin
						next_count = `TMR_CNT_ZERO;
						next_output_flipflop = !output_flipflop;
						match_evt = 1'b1;
					end else begin
						next_count = count_inc;
					end
				end
				tmr_pkg::tmr_pwm: begin
					// Full 8-bit wrap gives a 256 tick period
					next_count = count_inc;
					if (count == `TMR_CNT_MAX) begin
						next_output_flipflop = !output_flipflop;
						next_active_match = match_value_register;
						match_evt = 1'b1;
					end else if (count_inc == active_match) begin
						next_output_flipflop = !output_flipflop;
					end
				end
				default: next_count = count_inc;
			endcase
		end
		// Software preset of the flip-flop, meant only while stopped
		if (ctrl_wr) begin
			case (pwdata[`TMR_FF_MSB:`TMR_FF_LSB])
				`TMR_FF_CLEAR: next_output_flipflop = 1'b0;
				`TMR_FF_SET: next_output_flipflop = 1'b1;
				default: next_output_flipflop = next_output_flipflop;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= `TMR_CNT_ZERO;
			active_match <= `TMR_CNT_ZERO;
			output_flipflop <= 1'b0;
			run_prev <= 1'b0;
		end else if (ce) begin
			count <= next_count;
			active_match <= next_active_match;
			output_flipflop <= next_output_flipflop;
			run_prev <= next_run_prev;
		end
	end

	// Match value keeps its content across reset, so it has no reset branch
	always_comb begin
		next_match_value_register = match_value_register;
		if (match_wr)
			next_match_value_register = pwdata[7:0];
	end

	always_ff @(posedge pclk) begin
		if (ce)
			match_value_register <= next_match_value_register;
	end

	// Control, status and mask; a new event beats a same-cycle clear
	always_comb begin
		next_pwm_timer_control = pwm_timer_control;
		next_mask = mask;
		next_status = status;
		if (ctrl_wr)
			next_pwm_timer_control = pwdata[`TMR_CTRL_W-1:0];
		if (mask_wr)
			next_mask = pwdata[1:0];
		if (stat_wr)
			next_status = status & ~pwdata[1:0];
		if (match_evt)
			next_status[`TMR_STAT_MATCH] = 1'b1;
	end

	// Read data; write-only registers answer zero
	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			next_prdata = '0;
			case (paddr)
				`TMR_CTRL_ADDR: next_prdata = '0;
				`TMR_MATCH_ADDR: next_prdata = '0;
				`TMR_STAT_ADDR: begin
					next_prdata[`TMR_STAT_MATCH] = status[`TMR_STAT_MATCH];
					next_prdata[`TMR_STAT_FF] = output_flipflop;
					next_prdata[`TMR_STAT_CNT_MSB:`TMR_STAT_CNT_LSB] = count;
				end
				`TMR_MASK_ADDR: next_prdata[1:0] = mask;
				default: next_prdata = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_timer_control <= `TMR_CTRL_RST;
			mask <= 2'h0;
			status <= 2'h0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pwm_timer_control <= next_pwm_timer_control;
			mask <= next_mask;
			status <= next_status;
			prdata <= next_prdata;
		end
	end

	// Level interrupt while an unmasked status bit stands
	assign match_interrupt = |(status & mask);

	// Pin shows the inverted flip-flop only when a waveform mode is active
	assign shared_port_pin = ((mode == tmr_pkg::tmr_divider) || (mode == tmr_pkg::tmr_pwm)) ?
		!output_flipflop : 1'b1;
endmodule
`default_nettype wire

/* test/tmr_timer8_sva.sv */
// Port-level assertion checker for the 8-bit timer
`timescale 1ns/10ps
`default_nettype none
module tmr_timer8_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic shared_port_pin,
	input wire logic match_interrupt
);
	logic wr_ctrl, wr_mask, wr_stat, mapped, run_q, msk_q;
	logic [1:0] mode_q;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Decode of completed writes
	assign wr_ctrl = psel && penable && pready && pwrite && paddr == 12'h000;
	assign wr_mask = psel && penable && pready && pwrite && paddr == 12'h00c;
	assign wr_stat = psel && penable && pready && pwrite && paddr == 12'h008;
	assign mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
	// Shadow of control and mask settings; the control register cannot be read back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
			mode_q <= 2'h0;
			msk_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				run_q <= pwdata[4];
				mode_q <= pwdata[6:5];
			end
			if (wr_mask) begin
				msk_q <= pwdata[0];
			end
		end
	end
	property p_rd_zero;
		psel && penable && !pwrite && paddr[11:3] == 9'h000 |-> prdata == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("write-only register read non-zero");
	property p_slverr;
		psel && penable |-> pslverr == !mapped;
	endproperty
	a_slverr: assert property (p_slverr) else $error("error response wrong for address");
	property p_pin_idle;
		!mode_q[1] |-> shared_port_pin;
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("pin driven outside output modes");
	property p_reset_pin;
		$rose(presetn) |-> shared_port_pin ##1 shared_port_pin;
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("pin low after reset");
	property p_irq_cause;
		$rose(match_interrupt) |-> $past(run_q) || $past(wr_mask);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt rose while stopped");
	property p_irq_fall;
		$fell(match_interrupt) |-> $past(wr_stat) || $past(wr_mask);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
	property p_pwm_gap;
		run_q && $past(run_q) && mode_q == 2'h3 && $changed(shared_port_pin) |=> $stable(shared_port_pin)[*4];
	endproperty
	a_pwm_gap: assert property (p_pwm_gap) else $error("pwm output toggled too soon");
	property p_div_irq;
		run_q && $past(run_q) && msk_q && mode_q == 2'h2 && $changed(shared_port_pin) |-> match_interrupt;
	endproperty
	a_div_irq: assert property (p_div_irq) else $error("divider toggle without interrupt");
	// Main scenarios reached
	c_irq: cover property ($rose(match_interrupt));
	c_slverr: cover property (psel && penable && pslverr);
	c_pwm: cover property (mode_q == 2'h3 && $changed(shared_port_pin));
endmodule
bind tmr_timer8 tmr_timer8_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.shared_port_pin(shared_port_pin), .match_interrupt(match_interrupt));
`default_nettype wire

/* test/tmr_event_src.sv */
// Model of the external event source on the event pin
`timescale 1ns/10ps
`default_nettype none
module tmr_event_src (
	// Clock
	input wire logic pclk,
	// Level length in clocks
	input wire logic [7:0] half,
	// Event pin
	output logic event_input_pin
);
	logic [7:0] cnt = 8'h00;
	initial event_input_pin = 1'b0;
	// Free square wave; each level held for half clocks, one clock when half is below two
	always @(posedge pclk) begin
		if (cnt + 8'h01 >= half) begin
			cnt <= 8'h00;
			event_input_pin <= ~event_input_pin;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* test/tmr_timer8_tb_top.sv */
// Self-checking bench for the 8-bit timer
`timescale 1ns/10ps
`default_nettype none
module tmr_timer8_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic low_freq_mode = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, shared_port_pin, match_interrupt, event_input_pin, sl;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	int t0, t1;
	logic [31:0] cc [8] = '{32'h182, 32'h184, 32'h187, 32'h1a0, 32'h1a8, 32'h1c2, 32'h1e7, 32'h1e6};
	logic [7:0] cm [8] = '{8'h03, 8'h02, 8'h02, 8'h02, 8'h02, 8'h04, 8'h64, 8'h64};
	int cp [8] = '{24, 64, 0, 12, 12, 32, 256, 512};
	tmr_timer8 i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_input_pin(event_input_pin), .low_freq_mode(low_freq_mode),
		.shared_port_pin(shared_port_pin), .match_interrupt(match_interrupt));
	tmr_event_src i_src (.pclk(pclk), .half(8'h03), .event_input_pin(event_input_pin));
	always #5 pclk = ~pclk;
	// Cycle count, also cuts a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			fails++;
			conclude();
		end
	end
	task conclude;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Wait for the interrupt or a pin change; -1 when nothing comes
	task wait_ev(input logic pin, output int t);
		logic p0;
		int n;
		p0 = shared_port_pin;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while ((pin ? shared_port_pin === p0 : match_interrupt !== 1'b1) && n < 3000);
		t = n < 3000 ? cyc : -1;
	endtask
	// Configure while stopped, run, time two interrupts; zero match keeps the old value
	task run_case(input logic [31:0] c, input logic [7:0] m, input int per);
		if (m != 8'h00)
			apb(1'b1, 12'h004, {24'h0, m});
		apb(1'b1, 12'h000, c);
		apb(1'b1, 12'h000, c | 32'h10);
		apb(1'b1, 12'h008, 32'h1);
		wait_ev(1'b0, t0);
		apb(1'b1, 12'h008, 32'h1);
		wait_ev(1'b0, t1);
		chk(32'(t1 - t0), 32'(per), "period");
		apb(1'b0, 12'h008, 32'h0);
		chk({31'h0, shared_port_pin}, {31'h0, c[6] ? ~rd[1] : 1'b1}, "pin");
		apb(1'b1, 12'h000, c);
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 16; a += 4) begin
			apb(1'b0, 12'(a), 32'h0);
			chk(rd, 32'h0, "reset read");
		end
		chk({31'h0, shared_port_pin}, 32'h1, "reset pin");
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, sl}, 32'h1, "unmapped");
		apb(1'b1, 12'h00c, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h1, "mask");
		for (int i = 0; i < 8; i++)
			run_case(cc[i], cm[i], cp[i]);
		low_freq_mode <= 1'b1;
		run_case(32'h182, 8'h03, 0);
		low_freq_mode <= 1'b0;
		// New compare value waits for the period end
		apb(1'b1, 12'h004, 32'h64);
		apb(1'b1, 12'h000, 32'h1e7);
		apb(1'b1, 12'h000, 32'h1f7);
		apb(1'b1, 12'h008, 32'h1);
		wait_ev(1'b0, t0);
		apb(1'b1, 12'h004, 32'h32);
		wait_ev(1'b1, t1);
		chk(32'(t1 - t0), 32'd100, "old duty");
		apb(1'b1, 12'h008, 32'h1);
		wait_ev(1'b0, t0);
		wait_ev(1'b1, t1);
		chk(32'(t1 - t0), 32'd50, "new duty");
		// Reset in mid-run keeps the match value
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 12'h00c, 32'h1);
		run_case(32'h182, 8'h00, 400);
		conclude();
	end
endmodule
`default_nettype wire
